// >>> inc/jsr_pkg.sv
package jsr_pkg;

  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [3:0] JSR_OFS_INSTR = 4'h0;
  localparam logic [3:0] JSR_OFS_STATUS = 4'h4;
  localparam logic [3:0] JSR_OFS_CTRL = 4'h8;
  localparam logic [3:0] JSR_OFS_IDENT = 4'hc;
  localparam int JSR_CTRL_IRQ_CLR_BIT = 0;

  // ************************************************************
  // instruction_hold layout and reset values
  // ************************************************************
  localparam int JSR_IR_W = 16;
  localparam int JSR_CODE_W = 8;
  localparam logic [7:0] JSR_CODE_RESET = 8'hef;
  localparam logic [7:0] JSR_IR_FIXED_LOW = 8'hfd;
  localparam logic [31:0] JSR_IDENT_DEFAULT = 32'h00000001;

  // ************************************************************
  // boundary chain geometry
  // ************************************************************
  localparam int JSR_CHAIN_LEN = 469;
  localparam int JSR_CHAIN_TOP_CELL = 483;
  localparam int JSR_ID_W = 32;

  // ************************************************************
  // decoded commands and tap states
  // ************************************************************
  typedef enum logic [3:0] {
    JSR_OP_EXTEST,
    JSR_OP_CLAMP,
    JSR_OP_HIGHZ,
    JSR_OP_SAMPLE,
    JSR_OP_RST_NEG,
    JSR_OP_RST_AST,
    JSR_OP_DBG_IRQ,
    JSR_OP_IDCODE,
    JSR_OP_BYPASS,
    JSR_OP_RESERVED
  } jsr_op_t;

  typedef enum logic [3:0] {
    JSR_TLR, JSR_RTI, JSR_SEL_DR, JSR_CAP_DR, JSR_SHF_DR, JSR_EX1_DR,
    JSR_PAU_DR, JSR_EX2_DR, JSR_UPD_DR, JSR_SEL_IR, JSR_CAP_IR,
    JSR_SHF_IR, JSR_EX1_IR, JSR_PAU_IR, JSR_EX2_IR, JSR_UPD_IR
  } jsr_tap_t;

endpackage : jsr_pkg

// >>> hw/jsr_top.sv
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
// What this block does
// - one-bit bypass stage between serial in and out under bypass
// - bypass stage cleared to zero on every pass through capture-dr
// - sixteen-bit instruction hold, readable but never writable by software
// - instruction returns to identity code on test reset or reset state
// - new instruction accepted serially whatever the processor is doing
// - instruction code sits in upper eight bits, loaded from serial input
// - low byte reads fixed: bits 7..2 one, bit 1 zero, bit 0 one
// - top nibble 0000 extest, 0010 clamp, 0011 highz, 0100 sample
// - 0110 drops reset request, 0111 raises it, 101x requests debug irq
// - 1110 identity code (reset value ef), 1111 bypass, rest reserved
// - 469-stage boundary chain observing and controlling the pins
// - chain cells numbered down from serial in, cell 483 nearest it
// - test reset low resets the whole port asynchronously
module jsr_top
  import jsr_pkg::*;
#(
  parameter int CHAIN_LEN = JSR_CHAIN_LEN,
  // arbitrary neutral value, not any maker's code
  parameter logic [31:0] IDENT_WORD = JSR_IDENT_DEFAULT
)(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic trst_n_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  input wire logic [CHAIN_LEN-1:0] chain_capture_in,
  output logic [CHAIN_LEN-1:0] chain_update_out,
  output logic test_drive_out,
  output logic test_float_out,
  output logic reset_request_out,
  output logic debug_irq_out,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);

  // ************************************************************
  // command decode
  // ************************************************************
  function automatic jsr_op_t decode_op(input logic [7:0] code);
    jsr_op_t op;
    op = JSR_OP_RESERVED;
    // low nibble is ignored on purpose
    case (code[7:4])
      4'h0: op = JSR_OP_EXTEST;
      4'h2: op = JSR_OP_CLAMP;
      4'h3: op = JSR_OP_HIGHZ;
      4'h4: op = JSR_OP_SAMPLE;
      4'h6: op = JSR_OP_RST_NEG;
      4'h7: op = JSR_OP_RST_AST;
      4'ha, 4'hb: op = JSR_OP_DBG_IRQ;
      4'he: op = JSR_OP_IDCODE;
      4'hf: op = JSR_OP_BYPASS;
      default: op = JSR_OP_RESERVED;
    endcase
    return op;
  endfunction : decode_op
  function automatic jsr_tap_t tap_next(input jsr_tap_t s, input logic m);
    jsr_tap_t n;
    n = s;
    case (s)
      JSR_TLR: n = m ? JSR_TLR : JSR_RTI;
      JSR_RTI: n = m ? JSR_SEL_DR : JSR_RTI;
      JSR_SEL_DR: n = m ? JSR_SEL_IR : JSR_CAP_DR;
      JSR_CAP_DR: n = m ? JSR_EX1_DR : JSR_SHF_DR;
      JSR_SHF_DR: n = m ? JSR_EX1_DR : JSR_SHF_DR;
      JSR_EX1_DR: n = m ? JSR_UPD_DR : JSR_PAU_DR;
      JSR_PAU_DR: n = m ? JSR_EX2_DR : JSR_PAU_DR;
      JSR_EX2_DR: n = m ? JSR_UPD_DR : JSR_SHF_DR;
      JSR_UPD_DR: n = m ? JSR_SEL_DR : JSR_RTI;
      JSR_SEL_IR: n = m ? JSR_TLR : JSR_CAP_IR;
      JSR_CAP_IR: n = m ? JSR_EX1_IR : JSR_SHF_IR;
      JSR_SHF_IR: n = m ? JSR_EX1_IR : JSR_SHF_IR;
      JSR_EX1_IR: n = m ? JSR_UPD_IR : JSR_PAU_IR;
      JSR_PAU_IR: n = m ? JSR_EX2_IR : JSR_PAU_IR;
      JSR_EX2_IR: n = m ? JSR_UPD_IR : JSR_SHF_IR;
      JSR_UPD_IR: n = m ? JSR_SEL_DR : JSR_RTI;
      default: n = JSR_TLR;
    endcase
    return n;
  endfunction : tap_next
  // ************************************************************
  // reset release and pin synchronisers
  // ************************************************************
  logic rst_s1;
  logic rst_n;
  logic tap_rst_n;
  logic [2:0] tck_s1;
  logic [2:0] pin_s2;
  logic tck_d;
  logic tck_rise;
  logic tck_fall;
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // test reset acts without the clock, only constants are loaded
  assign tap_rst_n = rst_n & trst_n_in;
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tck_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      tck_d <= 1'b0;
    end
    else
    begin
      tck_s1 <= {tck_in, tms_in, tdi_in};
      pin_s2 <= tck_s1;
      tck_d <= pin_s2[2];
    end
  end

  // tck must stay below a quarter of clock_in to be seen reliably
  assign tck_rise = pin_s2[2] & ~tck_d;
  assign tck_fall = ~pin_s2[2] & tck_d;
  // ************************************************************
  // tap state
  // ************************************************************
  jsr_tap_t tap_state;
  always_ff @(posedge clock_in or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      tap_state <= JSR_TLR;
    else if (tck_rise)
      tap_state <= tap_next(tap_state, pin_s2[1]);
  end

  // ************************************************************
  // instruction path
  // ************************************************************
  logic [JSR_CODE_W-1:0] instruction_code;
  logic [JSR_IR_W-1:0] ir_shift;
  logic [JSR_IR_W-1:0] instruction_hold;
  jsr_op_t op_q;
  assign instruction_hold = {instruction_code, JSR_IR_FIXED_LOW};
  always_ff @(posedge clock_in or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      ir_shift <= {JSR_CODE_RESET, JSR_IR_FIXED_LOW};
      instruction_code <= JSR_CODE_RESET;
      op_q <= JSR_OP_IDCODE;
    end
    else if (tck_rise)
    begin
      if (tap_state == JSR_TLR)
      begin
        instruction_code <= JSR_CODE_RESET;
        op_q <= JSR_OP_IDCODE;
      end
      else if (tap_state == JSR_CAP_IR)
        ir_shift <= instruction_hold;
      else if (tap_state == JSR_SHF_IR)
        ir_shift <= {pin_s2[0], ir_shift[JSR_IR_W-1:1]};
      else if (tap_state == JSR_UPD_IR)
      begin
        // unassigned codes land in the reserved op and select bypass
        instruction_code <= ir_shift[15:8];
        op_q <= decode_op(ir_shift[15:8]);
      end
    end
  end

  // ************************************************************
  // data registers
  // ************************************************************
  logic bypass_stage;
  logic [JSR_ID_W-1:0] id_shift;
  logic [CHAIN_LEN-1:0] pin_scan_chain;
  logic chain_sel;
  assign chain_sel = (op_q == JSR_OP_EXTEST) || (op_q == JSR_OP_SAMPLE);
  always_ff @(posedge clock_in or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      bypass_stage <= 1'b0;
    else if (tck_rise && tap_state == JSR_CAP_DR)
      bypass_stage <= 1'b0;
    else if (tck_rise && tap_state == JSR_SHF_DR)
      bypass_stage <= pin_s2[0];
  end
  always_ff @(posedge clock_in or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      id_shift <= 32'h00000000;
    else if (tck_rise && tap_state == JSR_CAP_DR)
      id_shift <= IDENT_WORD;
    else if (tck_rise && tap_state == JSR_SHF_DR)
      id_shift <= {pin_s2[0], id_shift[JSR_ID_W-1:1]};
  end
  // index CHAIN_LEN-1 is cell JSR_CHAIN_TOP_CELL, fed straight from tdi
  always_ff @(posedge clock_in or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      pin_scan_chain <= '0;
    else if (tck_rise && chain_sel && tap_state == JSR_CAP_DR)
      pin_scan_chain <= chain_capture_in;
    else if (tck_rise && chain_sel && tap_state == JSR_SHF_DR)
      pin_scan_chain <= {pin_s2[0], pin_scan_chain[CHAIN_LEN-1:1]};
  end
  // update cells only move under chain ops, so clamp keeps what was loaded
  always_ff @(posedge clock_in or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      chain_update_out <= '0;
    else if (tck_rise && chain_sel && tap_state == JSR_UPD_DR)
      chain_update_out <= pin_scan_chain;
  end
  always_ff @(posedge clock_in or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      test_drive_out <= 1'b0;
      test_float_out <= 1'b0;
    end
    else
    begin
      test_drive_out <= (op_q == JSR_OP_EXTEST) || (op_q == JSR_OP_CLAMP);
      test_float_out <= (op_q == JSR_OP_HIGHZ);
    end
  end

  // ************************************************************
  // serial output, changes on the falling tck edge
  // ************************************************************
  always_ff @(posedge clock_in or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      tdo_out <= 1'b0;
      tdo_oe_n_out <= 1'b1;
    end
    else if (tck_fall)
    begin
      tdo_oe_n_out <= !(tap_state == JSR_SHF_IR || tap_state == JSR_SHF_DR);
      if (tap_state == JSR_SHF_IR)
        tdo_out <= ir_shift[0];
      else if (chain_sel)
        tdo_out <= pin_scan_chain[0];
      else if (op_q == JSR_OP_IDCODE)
        tdo_out <= id_shift[0];
      else
        tdo_out <= bypass_stage;
    end
  end

  // ************************************************************
  // side effects of loaded commands
  // ************************************************************
  logic upd_ir_now;
  logic irq_clr;
  assign upd_ir_now = tck_rise && tap_state == JSR_UPD_IR;
  always_ff @(posedge clock_in or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      reset_request_out <= 1'b0;
    else if (upd_ir_now && decode_op(ir_shift[15:8]) == JSR_OP_RST_AST)
      reset_request_out <= 1'b1;
    else if (upd_ir_now && decode_op(ir_shift[15:8]) == JSR_OP_RST_NEG)
      reset_request_out <= 1'b0;
  end
  // a new request beats a software clear in the same cycle
  always_ff @(posedge clock_in or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      debug_irq_out <= 1'b0;
    else if (upd_ir_now && decode_op(ir_shift[15:8]) == JSR_OP_DBG_IRQ)
      debug_irq_out <= 1'b1;
    else if (irq_clr)
      debug_irq_out <= 1'b0;
  end
  // ************************************************************
  // avalon slave, fixed one wait state
  // ************************************************************
  logic bus_ack;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~bus_ack;
  // software may only clear the irq; instruction_hold ignores writes
  assign irq_clr = avs_write_in && bus_ack && avs_address_in == JSR_OFS_CTRL
    && avs_byteenable_in[0] && avs_writedata_in[JSR_CTRL_IRQ_CLR_BIT];
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      bus_ack <= 1'b0;
    else
      bus_ack <= (avs_read_in | avs_write_in) & ~bus_ack;
  end

  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata_out <= 32'h00000000;
    else if (avs_read_in && !bus_ack)
    begin
      case (avs_address_in)
        JSR_OFS_INSTR: avs_readdata_out <= {16'h0000, instruction_hold};
        JSR_OFS_STATUS: avs_readdata_out <= {24'h000000, tap_state,
          test_float_out, test_drive_out, debug_irq_out, reset_request_out};
        JSR_OFS_IDENT: avs_readdata_out <= IDENT_WORD;
        default: avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_BYP_CAPT: assert property (@(posedge clock_in) disable iff (!tap_rst_n)
    (tck_rise && tap_state == JSR_CAP_DR) |=> !bypass_stage)
    else $error("bypass stage not cleared at capture-dr");
  AST_IR_TLR: assert property (@(posedge clock_in) disable iff (!tap_rst_n)
    (tck_rise && tap_state == JSR_TLR) |=> instruction_code == JSR_CODE_RESET
      && op_q == JSR_OP_IDCODE)
    else $error("instruction not reset to identity code");
  AST_IR_LOAD: assert property (@(posedge clock_in) disable iff (!tap_rst_n)
    upd_ir_now |=> instruction_code == $past(ir_shift[15:8]))
    else $error("instruction code not taken from shifted bits");
  AST_IR_LOW: assert property (@(posedge clock_in) disable iff (!tap_rst_n)
    tck_rise && tap_state == JSR_CAP_IR |=> ir_shift[7:0] == 8'hfd)
    else $error("fixed low byte of instruction wrong");
  AST_BYP_OUT: assert property (@(posedge clock_in) disable iff (!tap_rst_n)
    (tck_fall && tap_state == JSR_SHF_DR && op_q == JSR_OP_BYPASS)
      |=> tdo_out == $past(bypass_stage) && !tdo_oe_n_out)
    else $error("bypass stage not on serial output");
  AST_HIGHZ: assert property (@(posedge clock_in) disable iff (!tap_rst_n)
    (op_q == JSR_OP_HIGHZ) [*2] |-> test_float_out && !test_drive_out)
    else $error("highz does not float pins");
  AST_SAMPLE: assert property (@(posedge clock_in) disable iff (!tap_rst_n)
    (op_q == JSR_OP_SAMPLE) [*2] |-> !test_drive_out && !test_float_out)
    else $error("sample disturbs pins");
  AST_CHAIN_SHIFT: assert property (@(posedge clock_in) disable iff (!tap_rst_n)
    (tck_rise && chain_sel && tap_state == JSR_SHF_DR)
      |=> pin_scan_chain[CHAIN_LEN-1] == $past(pin_s2[0])
      && pin_scan_chain[CHAIN_LEN-2] == $past(pin_scan_chain[CHAIN_LEN-1]))
    else $error("chain shift broken");
  AST_RST_REQ: assert property (@(posedge clock_in) disable iff (!tap_rst_n)
    (upd_ir_now && ir_shift[15:12] == 4'h7) |=> reset_request_out)
    else $error("reset request not raised");
  AST_IRQ_WINS: assert property (@(posedge clock_in) disable iff (!tap_rst_n)
    (upd_ir_now && ir_shift[15:13] == 3'h5) |=> debug_irq_out)
    else $error("debug irq request lost");
endmodule : jsr_top

// >>> dv/jsr_tester.sv
`timescale 1ns/10ps
// ************************************************************
// serial tester on the far side of the test port
// ************************************************************
module jsr_tester
(
  input wire logic clk_in,
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic trst_n_out
);
  // test clock stands low outside frames
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
    trst_n_out = 1'b0;
  end

  // one test clock period of 9 system clocks; tdo sampled late in the
  // high phase, since the port answers some clocks after the fall
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clk_in);
    tms_out <= m;
    tdi_out <= d;
    repeat (4) @(posedge clk_in);
    tck_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    o = tdo_in;
    @(posedge clk_in);
    tck_out <= 1'b0;
  endtask : step

  task automatic to_idle;
    logic o;
    step(1'b0, 1'b0, o);
    @(posedge clk_in);
    tdi_out <= ~tdi_out;
  endtask : to_idle

  task automatic pulse_trst;
    @(posedge clk_in);
    trst_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    trst_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    to_idle();
  endtask : pulse_trst

  task automatic tlr;
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    to_idle();
  endtask : tlr

  // from idle: shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n,
                      input logic [468:0] din, output logic [468:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir)
      step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    to_idle();
  endtask : scan
endmodule : jsr_tester

// >>> dv/tb_top.sv
`timescale 1ns/10ps
// ************************************************************
// bench for the scan register block
// ************************************************************
module tb_top;
  import jsr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tdi, trst_n, tdo, drive, flt, rreq, dirq, oe_n;
  logic [468:0] cap = '0;
  logic [468:0] upd;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_r;
  logic [479:0] pa = {15{32'h5a3c96e1}};
  logic [479:0] pb = {15{32'hc7103e5b}};
  logic [7:0] codes [9] = '{8'h05, 8'h2a, 8'h3f, 8'h40, 8'h7c, 8'h61,
                            8'ha3, 8'hb0, 8'hf6};
  logic [3:0] stat [9] = '{4'h4, 4'h4, 4'h8, 4'h0, 4'h1, 4'h0,
                           4'h2, 4'h2, 4'h2};
  int n_errors = 0;
  int n_checks = 0;
  int oe_bits = 0;

  always #4 clk = ~clk;

  // tdo enable is seen low at exactly one tck fall per shifted bit
  always @(negedge tck)
    if (oe_n === 1'b0)
      oe_bits++;

  jsr_tester tst (.clk_in(clk), .tdo_in(tdo), .tck_out(tck),
    .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n));

  jsr_top dut (.clock_in(clk), .rst_n_in(rst_n), .tck_in(tck),
    .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo),
    .tdo_oe_n_out(oe_n), .chain_capture_in(cap), .chain_update_out(upd),
    .test_drive_out(drive), .test_float_out(flt),
    .reset_request_out(rreq), .debug_irq_out(dirq),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r));

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: word %h not %h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_chain(input logic [468:0] g, input logic [468:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: chain mismatch", $time);
    end
  endtask : chk_chain

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int t;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (wait_r !== 1'b0 && t < 50);
    q = rdata;
    chk_word({31'h0, wait_r}, 32'h0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk_word(q, e);
  endtask : rd_chk

  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic load(input logic [7:0] c);
    logic [468:0] dout;
    tst.scan(1'b1, 16, {453'h0, c, 8'h00}, dout);
  endtask : load

  initial
  begin
    logic [468:0] dout;
    logic [31:0] q;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    tst.pulse_trst();
    rd_chk(JSR_OFS_INSTR, 32'h0000effd);
    bus(1'b1, JSR_OFS_INSTR, 32'h00001234, q);
    rd_chk(JSR_OFS_INSTR, 32'h0000effd);
    rd_chk(4'h2, 32'h0);
    rd_chk(JSR_OFS_CTRL, 32'h0);
    tst.scan(1'b1, 16, {453'h0, 16'hef00}, dout);
    chk_word({16'h0, dout[15:0]}, 32'h0000effd);
    tst.scan(1'b0, 32, '0, dout);
    chk_word(dout[31:0], JSR_IDENT_DEFAULT);
    rd_chk(JSR_OFS_IDENT, JSR_IDENT_DEFAULT);
    $display("test reset and identity done");
    for (int i = 0; i < 9; i++)
    begin
      load(codes[i]);
      rd_chk(JSR_OFS_INSTR, {16'h0, codes[i], 8'hfd});
      rd_chk(JSR_OFS_STATUS, {24'h0, 4'h1, stat[i]});
      chk_word({30'h0, dirq, rreq}, {30'h0, stat[i][1:0]});
    end
    bus(1'b1, JSR_OFS_CTRL, 32'h1, q);
    rd_chk(JSR_OFS_STATUS, 32'h10);
    chk_word({30'h0, dirq, rreq}, 32'h0);
    $display("test command decode done");
    // second pass starts from 0 too, capture-dr clears the 1 left in the stage by the first
    repeat (2)
    begin
      tst.scan(1'b0, 8, {461'h0, 8'hff}, dout);
      chk_word({24'h0, dout[7:0]}, 32'hfe);
    end
    $display("test bypass done");
    load(8'h40);
    oe_bits = 0;
    @(posedge clk);
    cap <= pa[468:0];
    tst.scan(1'b0, 469, pb[468:0], dout);
    chk_chain(dout, pa[468:0]);
    chk_chain(upd, pb[468:0]);
    chk_word(oe_bits, 469);
    chk_word({31'h0, oe_n}, 32'h1);
    chk_word({30'h0, flt, drive}, 32'h0);
    load(8'h00);
    chk_word({30'h0, flt, drive}, 32'h1);
    chk_chain(upd, pb[468:0]);
    $display("test boundary chain done");
    load(8'hf0);
    tst.pulse_trst();
    rd_chk(JSR_OFS_INSTR, 32'h0000effd);
    load(8'hf0);
    tst.tlr();
    rd_chk(JSR_OFS_INSTR, 32'h0000effd);
    $display("test port reset done");
    close_out();
  end

  initial
  begin
    #400000;
    n_errors++;
    $display("wrong value at %0t: run timed out", $time);
    close_out();
  end
endmodule : tb_top
